// ### shared/wdtc_pkg.sv
/*
 * wdtc_pkg: constants shared by the watchdog timeout control block.
 * Assumes a 32-bit AXI4-Lite register bus and an 8-bit control register.
 */
package wdtc_pkg;

    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET       = 8'h00;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h04;
    localparam logic [7:0] IRQ_MASK_OFFSET   = 8'h08;
    localparam int         ADDR_LSB_BITS     = 8;

    // watchdog_control field positions
    localparam int PRESCALE_MSB      = 7;
    localparam int PRESCALE_LSB      = 4;
    localparam int INT_SELECT_BIT    = 3;
    localparam int STATUS_FLAG_BIT   = 2;
    localparam int REFRESH_EN_BIT    = 1;
    localparam int WRITE_UNLOCK_BIT  = 0;

    // watchdog_control power-on value: prescale code 1, all else clear
    localparam logic [7:0] CTRL_RESET        = 8'h10;

    // prescale codes
    localparam logic [3:0] PRESCALE_MAX_TIMED = 4'h7;
    localparam logic [3:0] PRESCALE_IMMEDIATE = 4'h8;

    // timeout base: 2^9 periods of the 32 kHz watchdog clock
    localparam int          LF_CLOCK_HZ        = 32768;
    localparam int          TIMEOUT_BASE_EXP   = 9;
    localparam logic [16:0] TIMEOUT_BASE_TICKS = 17'h00200;
    localparam int          COUNT_WIDTH        = 17;

    // interrupt status / mask layout
    localparam int IRQ_TIMEOUT_BIT = 0;
    localparam int IRQ_WIDTH       = 1;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### src/wdtc_top.sv
/*
 * wdtc_top: watchdog timeout control and status behind an AXI4-Lite slave.
 * Assumes the 32 kHz watchdog clock arrives as an asynchronous pin, the
 * supply-monitor interrupt comes from logic on clk_i, and sys_rst_i is the
 * external hardware reset (a watchdog reset is requested, not taken here).
 */
// What this block does
// - with interrupt select set and a timed prescale code (0-7), expiry raises the watchdog interrupt, no system reset.
// - watchdog interrupt is never gated by the global interrupt enable.
// - watchdog interrupt is always high priority; software cannot change it.
// - every timeout sets the status flag, whether reset or interrupt follows.
// - status flag clears only by software writing 0 or external reset.
// - software setting refresh enable enables the watchdog and restarts counting from zero.
// - no refresh before timeout gives reset or interrupt per interrupt select; codes 8 and above always give reset.
// - refresh enable clears on software 0 or on a watchdog reset expiry.
// - refresh enable also clears on hardware reset and supply-monitor interrupt.
// - timeout equals 2^prescale times 512 watchdog clock periods, codes 0-7.
// - control write takes effect only right after a write-unlock access.
// - counter advances on the 32 kHz watchdog clock, not the core clock.
`timescale 1ns/1ns
module wdtc_top (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        wdt_lf_clk_i,
    input  wire logic        supply_monitor_irq_i,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             sys_reset_req_o,
    output logic             wdt_irq_o,
    output logic             wdt_irq_high_prio_o,
    output logic             irq_o
);

    // all block state lives in one packed struct: one always_comb fills
    // a copy, one always_ff registers it; nothing else holds state.
    // the struct falls into five groups:
    //   - synchroniser for the asynchronous watchdog clock pin
    //   - the control fields software sees at the control offset
    //   - the timeout counter, cleared on enable and on every expiry
    //   - the interrupt status and mask pair
    //   - the bus slave, with one held address and one held data beat
    // outputs are copies of struct members so that every top-level
    // output comes straight from a flip-flop and never from a gate.
    typedef struct packed {
        // watchdog clock synchroniser and edge history
        logic        lf_meta;
        logic        lf_sync;
        logic        lf_prev;
        // watchdog_control fields and the timeout counter
        logic [3:0]  prescale;
        logic        int_select;
        logic        status_flag;
        logic        refresh_en;
        logic        unlock_armed;
        logic [wdtc_pkg::COUNT_WIDTH-1:0] count;
        // interrupt block
        logic [wdtc_pkg::IRQ_WIDTH-1:0] irq_status;
        logic [wdtc_pkg::IRQ_WIDTH-1:0] irq_mask;
        // bus slave
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [7:0]  w_byte;
        logic        w_lane0;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        // outputs
        logic        reset_req;
        logic        wdt_irq;
        logic        high_prio;
        logic        irq;
    } wdtc_state_t;

    wdtc_state_t state_q;
    wdtc_state_t state_d;

    // combinational helpers, all given a value on every path
    // limit: terminal count of the selected timed prescale code
    // lf_tick: one core cycle per synchronised watchdog clock rise
    // expire: the watchdog has run out this cycle
    // do_write / do_read: a bus write or read is carried out this cycle
    // ctrl_view: the control register as software reads it
    // rd_addr: low byte of the read address, the only decoded part
    logic [wdtc_pkg::COUNT_WIDTH-1:0] limit;
    logic                             lf_tick;
    logic                             expire;
    logic                             do_write;
    logic                             do_read;
    logic [7:0]                       ctrl_view;
    logic [7:0]                       rd_addr;

    // next-state logic for the whole block
    always_comb begin
        state_d = state_q;

        // watchdog clock pin: two flops, then edge detect on the second.
        // the core clock is far faster than the watchdog clock, so a
        // rise of the pin is never missed; the price is a fixed delay
        // of two to three core cycles before each tick counts.
        // only the second flop is read by logic, never the first.
        state_d.lf_meta = wdt_lf_clk_i;
        state_d.lf_sync = state_q.lf_meta;
        state_d.lf_prev = state_q.lf_sync;
        lf_tick = state_q.lf_sync & ~state_q.lf_prev;

        // terminal count: 512 << code, minus one for the zero start
        limit = (wdtc_pkg::TIMEOUT_BASE_TICKS << state_q.prescale[2:0])
                - 17'h00001;

        // expiry: timed codes wait for the limit, code 8 and above fire at once.
        // reserved codes act like the immediate code so that a stray
        // write can only shorten the timeout, never stretch it.
        expire = 1'b0;
        if (state_q.refresh_en) begin
            if (state_q.prescale > wdtc_pkg::PRESCALE_MAX_TIMED) begin
                expire = 1'b1;
            end else if (lf_tick && state_q.count == limit) begin
                expire = 1'b1;
            end
        end

        // counter only runs while enabled, on watchdog clock edges
        if (!state_q.refresh_en) begin
            state_d.count = '0;
        end else if (lf_tick) begin
            state_d.count = state_q.count + 17'h00001;
        end

        // one-cycle output strobes default low; the priority flag is held high
        state_d.reset_req = 1'b0;
        state_d.wdt_irq   = 1'b0;
        state_d.high_prio = 1'b1;

        if (expire) begin
            state_d.count = '0;
            if (state_q.int_select && state_q.prescale <= wdtc_pkg::PRESCALE_MAX_TIMED) begin
                // interrupt mode keeps the watchdog armed and counting again
                state_d.wdt_irq = 1'b1;
            end else begin
                state_d.reset_req  = 1'b1;
                state_d.refresh_en = 1'b0;
            end
        end

        // supply-monitor interrupt disarms the watchdog
        if (supply_monitor_irq_i) begin
            state_d.refresh_en = 1'b0;
        end

        // write channels: each address and data beat is held until paired.
        // address and data may arrive in either order; the write is only
        // carried out once both are held and no response is pending.
        // only byte lane 0 matters, the registers are 8 bits or less.
        if (s_axi_awvalid && state_q.awready) begin
            state_d.aw_held = 1'b1;
            state_d.aw_addr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && state_q.wready) begin
            state_d.w_held  = 1'b1;
            state_d.w_byte  = s_axi_wdata[7:0];
            state_d.w_lane0 = s_axi_wstrb[0];
        end

        do_write = state_q.aw_held & state_q.w_held & ~state_q.bvalid;
        do_read  = s_axi_arvalid & state_q.arready;

        if (do_write) begin
            state_d.aw_held = 1'b0;
            state_d.w_held  = 1'b0;
            state_d.bvalid  = 1'b1;
            state_d.bresp   = wdtc_pkg::RESP_OKAY;
            // any other access between unlock and write cancels the unlock
            state_d.unlock_armed = 1'b0;
            case (state_q.aw_addr)
                wdtc_pkg::CTRL_OFFSET: begin
                    if (state_q.w_lane0 && state_q.unlock_armed) begin
                        state_d.prescale   = state_q.w_byte[wdtc_pkg::PRESCALE_MSB:
                                                            wdtc_pkg::PRESCALE_LSB];
                        state_d.int_select = state_q.w_byte[wdtc_pkg::INT_SELECT_BIT];
                        if (!state_q.w_byte[wdtc_pkg::STATUS_FLAG_BIT]) begin
                            state_d.status_flag = 1'b0;
                        end
                        if (state_q.w_byte[wdtc_pkg::REFRESH_EN_BIT]) begin
                            state_d.refresh_en = 1'b1;
                            state_d.count      = '0;
                        end else begin
                            state_d.refresh_en = 1'b0;
                        end
                    end else if (state_q.w_lane0
                                 && state_q.w_byte[wdtc_pkg::WRITE_UNLOCK_BIT]) begin
                        // the unlock access changes nothing else
                        state_d.unlock_armed = 1'b1;
                    end
                end
                wdtc_pkg::IRQ_STATUS_OFFSET: begin
                    if (state_q.w_lane0) begin
                        state_d.irq_status = state_q.irq_status
                                             & ~state_q.w_byte[wdtc_pkg::IRQ_WIDTH-1:0];
                    end
                end
                wdtc_pkg::IRQ_MASK_OFFSET: begin
                    if (state_q.w_lane0) begin
                        state_d.irq_mask = state_q.w_byte[wdtc_pkg::IRQ_WIDTH-1:0];
                    end
                end
                default: begin
                    state_d.bresp = wdtc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (do_read) begin
            state_d.unlock_armed = 1'b0;
        end

        // hardware events win over a clear in the same cycle.
        // this ordering matters: a software clear landing on the very
        // cycle of an expiry must not lose the record of that timeout.
        if (expire) begin
            state_d.status_flag = 1'b1;
            state_d.irq_status[wdtc_pkg::IRQ_TIMEOUT_BIT] = 1'b1;
        end

        if (state_q.bvalid && s_axi_bready) begin
            state_d.bvalid = 1'b0;
        end

        // read channel: answer one cycle after the address is taken.
        // arready drops while the answer stands, so only one read is
        // ever outstanding and rdata need not be buffered.
        // unmapped offsets answer zero data with an error response.
        ctrl_view = {state_q.prescale, state_q.int_select, state_q.status_flag,
                     state_q.refresh_en, state_q.unlock_armed};
        rd_addr   = s_axi_araddr[7:0];
        if (do_read) begin
            state_d.arready = 1'b0;
            state_d.rvalid  = 1'b1;
            state_d.rresp   = wdtc_pkg::RESP_OKAY;
            state_d.rdata   = '0;
            case (rd_addr)
                wdtc_pkg::CTRL_OFFSET: begin
                    state_d.rdata[7:0] = ctrl_view;
                end
                wdtc_pkg::IRQ_STATUS_OFFSET: begin
                    state_d.rdata[wdtc_pkg::IRQ_WIDTH-1:0] = state_q.irq_status;
                end
                wdtc_pkg::IRQ_MASK_OFFSET: begin
                    state_d.rdata[wdtc_pkg::IRQ_WIDTH-1:0] = state_q.irq_mask;
                end
                default: begin
                    state_d.rresp = wdtc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (state_q.rvalid && s_axi_rready) begin
            state_d.rvalid  = 1'b0;
            state_d.arready = 1'b1;
        end

        // ready flags: only one write held at a time, so no beat is dropped
        state_d.awready = ~state_d.aw_held & ~state_d.bvalid;
        state_d.wready  = ~state_d.w_held & ~state_d.bvalid;

        // watchdog interrupt goes out ungated; global enable never sees it
        state_d.irq = |(state_d.irq_status & state_d.irq_mask);
    end

    // state register; apart from a software write of 0, only the external reset clears the status flag.
    // the watchdog's own reset request leaves this block untouched, so
    // the status flag survives it and software can tell why it woke.
    // readies come up high so the first request after reset is taken.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q              <= '0;
            state_q.prescale     <= wdtc_pkg::CTRL_RESET[wdtc_pkg::PRESCALE_MSB:
                                                         wdtc_pkg::PRESCALE_LSB];
            state_q.int_select   <= wdtc_pkg::CTRL_RESET[wdtc_pkg::INT_SELECT_BIT];
            state_q.status_flag  <= wdtc_pkg::CTRL_RESET[wdtc_pkg::STATUS_FLAG_BIT];
            state_q.refresh_en   <= wdtc_pkg::CTRL_RESET[wdtc_pkg::REFRESH_EN_BIT];
            state_q.unlock_armed <= wdtc_pkg::CTRL_RESET[wdtc_pkg::WRITE_UNLOCK_BIT];
            state_q.awready      <= 1'b1;
            state_q.wready       <= 1'b1;
            state_q.arready      <= 1'b1;
            state_q.high_prio    <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    // every output straight from the state register.
    // the high priority output is a constant one held in a flop; there
    // is no register bit that could lower it.
    assign s_axi_awready       = state_q.awready;
    assign s_axi_wready        = state_q.wready;
    assign s_axi_bvalid        = state_q.bvalid;
    assign s_axi_bresp         = state_q.bresp;
    assign s_axi_arready       = state_q.arready;
    assign s_axi_rvalid        = state_q.rvalid;
    assign s_axi_rdata         = state_q.rdata;
    assign s_axi_rresp         = state_q.rresp;
    assign sys_reset_req_o     = state_q.reset_req;
    assign wdt_irq_o           = state_q.wdt_irq;
    assign wdt_irq_high_prio_o = state_q.high_prio;
    assign irq_o               = state_q.irq;

endmodule // wdtc_top

// ### verif/wdtc_monitor.sv
/* wdtc_monitor: port-level checks of the watchdog control block.
   Assumes one clock domain, bound to wdtc_top with synchronous reset. */
`timescale 1ns/1ns
module wdtc_monitor (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic sys_reset_req_o,
    input wire logic wdt_irq_o,
    input wire logic wdt_irq_high_prio_o
);
    // single domain, so clock and reset are given once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_irq_no_reset: assert property (wdt_irq_o |-> !sys_reset_req_o)
        else $error("interrupt expiry also requested reset");
    a_prio_fixed: assert property (wdt_irq_high_prio_o)
        else $error("interrupt priority not high");
    a_irq_single: assert property (wdt_irq_o |=> !wdt_irq_o)
        else $error("interrupt pulse too long");
    a_rst_single: assert property (sys_reset_req_o |=> !sys_reset_req_o)
        else $error("reset pulse too long");
    // write answer two edges after a joint address and data beat
    a_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("late write response");
    a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("late read response");
    a_r_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_w_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
endmodule // wdtc_monitor

// ### verif/tb_wdtc_top.sv
/* tb_wdtc_top: directed scenarios for the watchdog control block.
   Assumes wdtc_pkg and the monitor are compiled first; lf ticks are sped up. */
`timescale 1ns/1ns
module tb_wdtc_top;
    logic        clk_i = 1'b0, sys_rst_i = 1'b1, lf = 1'b0, supply_monitor = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd;
    logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, rst_req, wirq, prio, irq;
    logic [1:0]  bresp, rresp, rs;
    int          miscompares = 0, checks_done = 0, irq_seen = 0, rst_seen = 0;

    wdtc_top uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wdt_lf_clk_i(lf),
        .supply_monitor_irq_i(supply_monitor), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sys_reset_req_o(rst_req), .wdt_irq_o(wirq), .wdt_irq_high_prio_o(prio),
        .irq_o(irq));

    // 50 MHz core clock
    initial begin
        forever #10 clk_i = ~clk_i;
    end

    // pulses last one cycle, so tally them as they pass
    always @(posedge clk_i) begin
        if (wirq === 1'b1) irq_seen++;
        if (rst_req === 1'b1) rst_seen++;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    // address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        awaddr <= {24'h000000, a};
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (awready) awv <= 1'b0;
            if (wready) wv <= 1'b0;
        end while (!bvalid && n < 100);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk_i);
        araddr <= {24'h000000, a};
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (arready) arv <= 1'b0;
        end while (!rvalid && n < 100);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rdr(a);
        chk(rd, e);
    endtask

    // unlocked control write: arm, then the real value
    task automatic cw(input logic [7:0] v);
        wr(wdtc_pkg::CTRL_OFFSET, 32'h01);
        wr(wdtc_pkg::CTRL_OFFSET, {24'h000000, v});
    endtask

    // watchdog clock ticks, two core cycles high and low
    task automatic tk(input int n);
        repeat (n) begin
            repeat (2) @(posedge clk_i);
            lf <= 1'b1;
            repeat (2) @(posedge clk_i);
            lf <= 1'b0;
        end
    endtask

    task automatic t_reset;
        rc(wdtc_pkg::CTRL_OFFSET, 32'h10);
        chk(prio, 1'b1);
        rdr(8'h0C);
        chk(rd, 32'h0);
        chk(rs, wdtc_pkg::RESP_SLVERR);
        wr(wdtc_pkg::CTRL_OFFSET, 32'h02);
        rc(wdtc_pkg::CTRL_OFFSET, 32'h10);
        wr(8'h0C, 32'h0);
        chk(rs, wdtc_pkg::RESP_SLVERR);
        wr(wdtc_pkg::CTRL_OFFSET, 32'h01);
        chk(rs, wdtc_pkg::RESP_OKAY);
        rc(wdtc_pkg::CTRL_OFFSET, 32'h11);
        wr(wdtc_pkg::CTRL_OFFSET, 32'h02);
        rc(wdtc_pkg::CTRL_OFFSET, 32'h10);
    endtask

    task automatic t_irq;
        wr(wdtc_pkg::IRQ_MASK_OFFSET, 32'h1);
        cw(8'h0A);
        tk(511);
        chk(irq_seen, 0);
        tk(1);
        repeat (10) @(posedge clk_i);
        chk(irq_seen, 1);
        chk(rst_seen, 0);
        chk(irq, 1'b1);
        rc(wdtc_pkg::CTRL_OFFSET, 32'h0E);
        wr(wdtc_pkg::IRQ_MASK_OFFSET, 32'h0);
        repeat (2) @(posedge clk_i);
        chk(irq, 1'b0);
        wr(wdtc_pkg::IRQ_MASK_OFFSET, 32'h1);
        wr(wdtc_pkg::IRQ_STATUS_OFFSET, 32'h1);
        repeat (2) @(posedge clk_i);
        chk(irq, 1'b0);
        cw(8'h00);
        rc(wdtc_pkg::CTRL_OFFSET, 32'h00);
    endtask

    task automatic t_rst;
        cw(8'h02);
        tk(300);
        cw(8'h02);
        tk(300);
        chk(rst_seen, 0);
        tk(212);
        repeat (10) @(posedge clk_i);
        chk(rst_seen, 1);
        rc(wdtc_pkg::CTRL_OFFSET, 32'h04);
        cw(8'h82);
        repeat (10) @(posedge clk_i);
        chk(rst_seen, 2);
        cw(8'h16);
        supply_monitor <= 1'b1;
        repeat (2) @(posedge clk_i);
        supply_monitor <= 1'b0;
        rc(wdtc_pkg::CTRL_OFFSET, 32'h14);
        sys_rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rc(wdtc_pkg::CTRL_OFFSET, 32'h10);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // hang guard, well past the expected run
    initial begin
        #1000000;
        miscompares++;
        give_verdict();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_irq();
        t_rst();
        give_verdict();
    end
endmodule // tb_wdtc_top

bind wdtc_top wdtc_monitor u_mon (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .sys_reset_req_o(sys_reset_req_o), .wdt_irq_o(wdt_irq_o),
    .wdt_irq_high_prio_o(wdt_irq_high_prio_o));
